// *** core/scsa_regs.vh ***
// Purpose: shared constants of the sync check slip/angle block
// Assumes: frequency in mHz, angle in 0.1 deg, voltage in 0.1 V,
//          close time in 0.01 cycle, one 32-bit word per register
// Notes:   included by the core only; definitions, no logic
// Functional notes
// - slip runs only when healthy and unblocked
// - slip is primary minus sync frequency, signed
// - slip_ok when slip magnitude below limit
// - one slip cycle equals 360 degrees
// - angle difference runs only while slip_ok
// - subtract phase select offset, 30 degree steps
// - slip at most 0.005 Hz is static
// - zero close time omits compensation
// - slipping adds slip times close time term
// - static: permissive when difference below limit
// - healthy when voltage inside low/high window
// - slipping with nonzero close time: permissive at zero, on a crossing or rising, below limit
`ifndef SCSA_REGS_VH
`define SCSA_REGS_VH
// register byte offsets
`define SCSA_MAX_SLIP   6'h00
`define SCSA_ANG_FIRST  6'h04
`define SCSA_ANG_SECOND 6'h08
`define SCSA_PHASE_SEL  6'h0c
`define SCSA_CLOSE_TIME 6'h10
`define SCSA_VOLT_LO    6'h14
`define SCSA_VOLT_HI    6'h18
`define SCSA_STATUS     6'h1c
`define SCSA_SLIP_RD    6'h20
`define SCSA_ANGLE_RD   6'h24
`define SCSA_IRQ_STAT   6'h28
`define SCSA_IRQ_MASK   6'h2c
// reset values
`define SCSA_RST_SLIP   16'h0032
`define SCSA_RST_ANG1   10'h096
`define SCSA_RST_ANG2   10'h0fa
`define SCSA_RST_PSEL   4'h0
`define SCSA_RST_TCLOSE 13'h0000
`define SCSA_RST_VLO    12'h190
`define SCSA_RST_VHI    12'h578
`define SCSA_RST_MASK   3'h0
// arithmetic constants (0.1 deg units, static limit in mHz)
`define SCSA_TURN       32'sh00000e10
`define SCSA_HALF       32'sh00000708
`define SCSA_STEP       13'h012c
`define SCSA_STATIC_MHZ 17'h00005
// 0.1deg = mHz/1000 * cc/100 / 60 * 360 * 10 = mHz*cc*3/5000
`define SCSA_COMP_NUM   32'sh00000003
`define SCSA_COMP_DEN   32'sh00001388
`endif

// *** core/scsa_core.v ***
// Purpose: slip frequency and angle difference sync check datapath
// Assumes: measurements come from logic on clk_in, one sample a cycle
// Notes:   avalon-mm slave, one wait state per access
`timescale 1ns/1ps
`default_nettype none
`include "scsa_regs.vh"
module scsa_core #(
  parameter FW = 16,  // frequency width, mHz
  parameter AW = 12,  // angle width, 0.1 deg
  parameter VW = 12   // voltage width, 0.1 V
) (
  input  wire          clk_in,
  input  wire          rst_in,
  input  wire          clk_en_in,
  input  wire [5:0]    avs_address_in,
  input  wire          avs_read_in,
  input  wire          avs_write_in,
  input  wire [31:0]   avs_writedata_in,
  input  wire [3:0]    avs_byteenable_in,
  output reg  [31:0]   avs_readdata_out,
  output reg           avs_waitrequest_out,
  input  wire [FW-1:0] freq_primary_in,
  input  wire [FW-1:0] freq_sync_in,
  input  wire [AW-1:0] angle_primary_in,
  input  wire [AW-1:0] angle_sync_in,
  input  wire [VW-1:0] volt_primary_in,
  input  wire [VW-1:0] volt_sync_in,
  input  wire [VW-1:0] volt_freq_ref_in,
  input  wire          sync_block_condition_in,
  output reg           primary_voltage_healthy_out,
  output reg           sync_voltage_healthy_out,
  output reg           freq_ref_voltage_healthy_out,
  output reg           slip_ok_out,
  output wire          sync_ok_first_out,
  output wire          sync_ok_second_out,
  output reg           irq_out
);

  // settings written by software, and the sticky event status
  reg [15:0] max_slip_limit;      // mHz
  reg [9:0]  max_angle_first;     // 0.1 deg
  reg [9:0]  max_angle_second;    // 0.1 deg
  reg [3:0]  phase_select_offset; // 30 deg steps
  reg [12:0] breaker_close_time;  // 0.01 cycle
  reg [VW-1:0] volt_lo;           // healthy window low
  reg [VW-1:0] volt_hi;           // healthy window high
  reg [2:0]  irq_mask;            // same layout as status
  reg [2:0]  irq_status;          // sticky events

  // pipeline state
  reg signed [16:0] slip;         // last computed slip, mHz
  reg [16:0]        slip_mag;     // its magnitude
  reg signed [12:0] raw_diff;     // wrapped raw angle diff
  reg [10:0]        angle_diff;   // last absolute difference
  reg               prev_valid;   // angle_diff holds a sample
  reg               prev_neg;     // sign of last difference
  reg [1:0]         sync_ok;      // permissive flags

  // bus state
  reg [31:0] next_rdata;          // readback mux
  wire bus_req = avs_read_in | avs_write_in;
  wire bus_acc = bus_req & ~avs_waitrequest_out;
  wire wr_acc  = avs_write_in & bus_acc;
  wire rd_acc  = avs_read_in & bus_acc;

  // window test used for all three voltages
  function in_window;
    input [VW-1:0] v;
    input [VW-1:0] lo;
    input [VW-1:0] hi;
    begin
      in_window = (v >= lo) && (v <= hi);
    end
  endfunction

  // fold any angle into -180..+180 degrees
  function signed [12:0] wrap_ang;
    input signed [31:0] x;
    reg signed [31:0] r;
    begin
      r = x % `SCSA_TURN;
      if (r > `SCSA_HALF) begin
        r = r - `SCSA_TURN;
      end else if (r < -`SCSA_HALF) begin
        r = r + `SCSA_TURN;
      end
      wrap_ang = r[12:0];
    end
  endfunction

  // merge written bytes into the old word
  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer i;
    begin
      be_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          be_merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  // written word: old value with the enabled byte lanes replaced;
  // each setting then takes only the bits it holds
  wire [31:0] wr_word = be_merge(next_rdata, avs_writedata_in,
                                 avs_byteenable_in);

  // healthy flags from the current samples
  wire h_p = in_window(volt_primary_in, volt_lo, volt_hi);
  wire h_s = in_window(volt_sync_in, volt_lo, volt_hi);
  wire h_f = in_window(volt_freq_ref_in, volt_lo, volt_hi);
  wire slip_run = h_p & h_s & h_f & ~sync_block_condition_in;

  // signed slip, primary side minus sync side
  wire signed [16:0] slip_d = $signed({1'b0, freq_primary_in}) -
                              $signed({1'b0, freq_sync_in});
  wire [16:0] slip_d_mag = slip_d[16] ? -slip_d : slip_d;
  wire next_slip_ok = slip_run &
                      (slip_d_mag < {1'b0, max_slip_limit});

  // constant sync lag removed from the raw difference
  wire [12:0] off_t = phase_select_offset * `SCSA_STEP;
  wire signed [31:0] raw_w = $signed({1'b0, angle_primary_in}) -
                             $signed({1'b0, angle_sync_in}) -
                             $signed({1'b0, off_t});

  // static when slip is at most 5 mHz
  wire is_static = slip_mag <= `SCSA_STATIC_MHZ;
  wire comp_on = ~is_static & (breaker_close_time != 13'h0000);
  // close-time travel; 360 deg per slip cycle in the scale
  wire signed [31:0] comp = (slip *
                            $signed({1'b0, breaker_close_time}) *
                            `SCSA_COMP_NUM) / `SCSA_COMP_DEN;
  wire signed [31:0] comp_sel = comp_on ? comp : 32'sh00000000;
  // compensated difference re-folded before the magnitude
  wire signed [12:0] sdiff = wrap_ang(raw_diff + comp_sel);
  wire [12:0] sdiff_mag = sdiff[12] ? -sdiff : sdiff;
  wire [10:0] adiff = sdiff_mag[10:0];
  wire crossed = prev_valid & (sdiff[12] != prev_neg);
  // the angle moves far slower than the clock, so a sample-to-sample
  // compare would grant for one cycle only; the slip sign tells whether
  // the magnitude is opening (same sign) or closing on zero
  wire rising  = (sdiff != 13'sh0000) & (sdiff[12] == slip[16]);
  wire [9:0] lim [0:1];
  assign lim[0] = max_angle_first;
  assign lim[1] = max_angle_second;

  // per-permissive decision, identical for both limits
  wire [1:0] next_sync_ok;
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_perm
      wire below = adiff < {1'b0, lim[k]};
      // slipping: grant at zero, on a crossing or while rising, when below
      wire slip_perm = below & ((adiff == 11'h000) | crossed |
                                rising);
      assign next_sync_ok[k] = slip_ok_out &
                               (comp_on ? slip_perm : below);
    end
  endgenerate
  assign sync_ok_first_out  = sync_ok[0];
  assign sync_ok_second_out = sync_ok[1];

  // rising permissives are the interrupt events
  wire [2:0] cur_flags = {sync_ok, slip_ok_out};
  wire [2:0] nxt_flags = {next_sync_ok, next_slip_ok};
  wire [2:0] events = nxt_flags & ~cur_flags;
  wire stat_clr = rd_acc & (avs_address_in == `SCSA_IRQ_STAT);
  // set wins: an event in the clearing cycle survives
  wire [2:0] next_irq_status = (stat_clr ? 3'h0 : irq_status) |
                               events;

  // slip stage: slip and slip_mag frozen outside the run condition
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      slip                         <= 17'sh00000;
      slip_mag                     <= 17'h00000;
      raw_diff                     <= 13'sh0000;
      slip_ok_out                  <= 1'b0;
      primary_voltage_healthy_out  <= 1'b0;
      sync_voltage_healthy_out     <= 1'b0;
      freq_ref_voltage_healthy_out <= 1'b0;
    end else if (clk_en_in) begin
      primary_voltage_healthy_out  <= h_p;
      sync_voltage_healthy_out     <= h_s;
      freq_ref_voltage_healthy_out <= h_f;
      slip_ok_out                  <= next_slip_ok;
      raw_diff                     <= wrap_ang(raw_w);
      if (slip_run) begin
        slip     <= slip_d;
        slip_mag <= slip_d_mag;
      end
    end
  end

  // angle stage: runs only while slip_ok holds
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      angle_diff <= 11'h000;
      prev_valid <= 1'b0;
      prev_neg   <= 1'b0;
      sync_ok    <= 2'h0;
    end else if (clk_en_in) begin
      sync_ok <= next_sync_ok;
      if (slip_ok_out) begin
        angle_diff <= adiff;
        prev_neg   <= sdiff[12];
        prev_valid <= 1'b1;
      end else begin
        // history is stale once the stage stops
        prev_valid <= 1'b0;
      end
    end
  end

  // readback mux; unmapped offsets read zero
  always @* begin
    next_rdata = 32'h00000000;
    case (avs_address_in)
      `SCSA_MAX_SLIP:   next_rdata[15:0] = max_slip_limit;
      `SCSA_ANG_FIRST:  next_rdata[9:0]  = max_angle_first;
      `SCSA_ANG_SECOND: next_rdata[9:0]  = max_angle_second;
      `SCSA_PHASE_SEL:  next_rdata[3:0]  = phase_select_offset;
      `SCSA_CLOSE_TIME: next_rdata[12:0] = breaker_close_time;
      `SCSA_VOLT_LO:    next_rdata[VW-1:0] = volt_lo;
      `SCSA_VOLT_HI:    next_rdata[VW-1:0] = volt_hi;
      `SCSA_STATUS:     next_rdata[5:0] = {sync_ok, slip_ok_out,
                          freq_ref_voltage_healthy_out,
                          sync_voltage_healthy_out,
                          primary_voltage_healthy_out};
      `SCSA_SLIP_RD:    next_rdata = {{15{slip[16]}}, slip};
      `SCSA_ANGLE_RD:   next_rdata[10:0] = angle_diff;
      `SCSA_IRQ_STAT:   next_rdata[2:0] = irq_status;
      `SCSA_IRQ_MASK:   next_rdata[2:0] = irq_mask;
      default:          next_rdata = 32'h00000000;
    endcase
  end

  // bus handshake: one wait cycle, then a one-cycle accept
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h00000000;
    end else if (clk_en_in) begin
      if (bus_req & avs_waitrequest_out) begin
        avs_waitrequest_out <= 1'b0;
        avs_readdata_out    <= next_rdata;
      end else begin
        avs_waitrequest_out <= 1'b1;
      end
    end
  end

  // settings written at the accepting edge only
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      max_slip_limit      <= `SCSA_RST_SLIP;
      max_angle_first     <= `SCSA_RST_ANG1;
      max_angle_second    <= `SCSA_RST_ANG2;
      phase_select_offset <= `SCSA_RST_PSEL;
      breaker_close_time  <= `SCSA_RST_TCLOSE;
      volt_lo             <= `SCSA_RST_VLO;
      volt_hi             <= `SCSA_RST_VHI;
      irq_mask            <= `SCSA_RST_MASK;
    end else if (clk_en_in & wr_acc) begin
      case (avs_address_in)
        `SCSA_MAX_SLIP:
          max_slip_limit <= wr_word[15:0];
        `SCSA_ANG_FIRST:
          max_angle_first <= wr_word[9:0];
        `SCSA_ANG_SECOND:
          max_angle_second <= wr_word[9:0];
        `SCSA_PHASE_SEL:
          phase_select_offset <= wr_word[3:0];
        `SCSA_CLOSE_TIME:
          breaker_close_time <= wr_word[12:0];
        `SCSA_VOLT_LO:
          volt_lo <= wr_word[VW-1:0];
        `SCSA_VOLT_HI:
          volt_hi <= wr_word[VW-1:0];
        `SCSA_IRQ_MASK:
          irq_mask <= wr_word[2:0];
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  // sticky status, read-to-clear; level interrupt
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_status <= 3'h0;
      irq_out    <= 1'b0;
    end else if (clk_en_in) begin
      irq_status <= next_irq_status;
      irq_out    <= |(next_irq_status & irq_mask);
    end
  end

endmodule // scsa_core
`default_nettype wire

// *** test/scsa_core_assertions.sv ***
// Purpose: port-level timing checks of scsa_core
// Assumes: one clock, asynchronous active-high reset
// Notes:   settings are invisible here, so setting-free relations except chk_full_volt
`timescale 1ns/1ps
`default_nettype none
module scsa_core_assertions #(
  parameter VW = 12
) (
  input wire logic          clk_in,
  input wire logic          rst_in,
  input wire logic          clk_en_in,
  input wire logic          avs_read_in,
  input wire logic          avs_write_in,
  input wire logic          avs_waitrequest_out,
  input wire logic [31:0]   avs_readdata_out,
  input wire logic [VW-1:0] volt_primary_in,
  input wire logic          sync_block_condition_in,
  input wire logic          primary_voltage_healthy_out,
  input wire logic          slip_ok_out,
  input wire logic          sync_ok_first_out,
  input wire logic          sync_ok_second_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire req = avs_read_in | avs_write_in; // any pending bus request
  // request seen while slave still waiting: the arming edge
  sequence s_arm;
    clk_en_in && req && avs_waitrequest_out;
  endsequence
  // block at one enabled edge reaches the permissives after a second enabled edge
  sequence s_block;
    clk_en_in && sync_block_condition_in ##1 clk_en_in;
  endsequence
  chk_wait_answer: assert property (s_arm |=> !avs_waitrequest_out)
    else $error("waitrequest did not drop after arming");
  chk_wait_one: assert property (clk_en_in && !avs_waitrequest_out
    |=> avs_waitrequest_out) else $error("waitrequest low too long");
  chk_wait_idle: assert property (!req |-> avs_waitrequest_out)
    else $error("waitrequest low without a request");
  chk_read_hold: assert property (!avs_waitrequest_out
    |=> $stable(avs_readdata_out)) else $error("readdata moved early");
  chk_block_slip: assert property (
    clk_en_in && sync_block_condition_in |=> !slip_ok_out)
    else $error("slip_ok high while blocked");
  // full scale lies above the reset high limit, so it is unhealthy unless volt_hi is written to full scale
  chk_full_volt: assert property (
    clk_en_in && volt_primary_in == {VW{1'b1}}
    |=> !primary_voltage_healthy_out)
    else $error("full-scale voltage reported healthy");
  chk_slip_gate: assert property (clk_en_in && !slip_ok_out
    |=> !sync_ok_first_out && !sync_ok_second_out)
    else $error("permissive without slip_ok");
  chk_block_sync: assert property (s_block
    |=> !sync_ok_first_out && !sync_ok_second_out)
    else $error("permissive while blocked");
endmodule // scsa_core_assertions
bind scsa_core scsa_core_assertions #(.VW(VW)) scsa_core_assertions_inst (
  .clk_in(clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out),
  .avs_readdata_out(avs_readdata_out), .volt_primary_in(volt_primary_in),
  .sync_block_condition_in(sync_block_condition_in),
  .primary_voltage_healthy_out(primary_voltage_healthy_out),
  .slip_ok_out(slip_ok_out), .sync_ok_first_out(sync_ok_first_out),
  .sync_ok_second_out(sync_ok_second_out));
`default_nettype wire

// *** test/scsa_sense_model.sv ***
// Purpose: sensing front end feeding frequency, angle and voltage
// Assumes: values change just after a rising edge and then hold
// Notes:   no noise; bench sets values through set_f and set_v
`timescale 1ns/1ps
`default_nettype none
module scsa_sense_model (
  input  wire logic        clk_in,
  output var  logic [15:0] fp_out,
  output var  logic [15:0] fs_out,
  output var  logic [11:0] ap_out,
  output var  logic [11:0] sa_out,
  output var  logic [11:0] vp_out,
  output var  logic [11:0] vs_out,
  output var  logic [11:0] vf_out
);
  // start at 60 Hz in phase with 120 V on all inputs
  initial begin
    {fp_out, fs_out} = {16'hea60, 16'hea60};
    {ap_out, sa_out} = 24'h0;
    {vp_out, vs_out, vf_out} = {12'h4b0, 12'h4b0, 12'h4b0};
  end
  // new phasor pair, launched on an edge so the core never races it
  task set_f(input [15:0] fp, input [15:0] fs, input [11:0] ap,
             input [11:0] sa);
    begin
      @(posedge clk_in);
      {fp_out, fs_out, ap_out, sa_out} <= {fp, fs, ap, sa};
    end
  endtask
  // new voltage magnitudes
  task set_v(input [11:0] vp, input [11:0] vs, input [11:0] vf);
    begin
      @(posedge clk_in);
      {vp_out, vs_out, vf_out} <= {vp, vs, vf};
    end
  endtask
endmodule // scsa_sense_model
`default_nettype wire

// *** test/scsa_core_tb_top.sv ***
// Purpose: self-checking bench of scsa_core over its avalon slave
// Assumes: byte lanes held fully on
// Notes:   waits of four cycles exceed the two-edge measurement path
`timescale 1ns/1ps
`default_nettype none
module scsa_core_tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [5:0] av_addr = 6'h0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic blk = 1'b0; // block condition
  logic en = 1'b1; // clock enable
  logic [31:0] rdata;
  integer n_errors = 0;
  integer total_checks = 0;
  integer k;
  wire [31:0] av_rdata;
  wire av_wait, hp, hs, hf, slip_ok, ok1, ok2, irq;
  wire [15:0] fp, fs;
  wire [11:0] ap, sa, vp, vs, vf;
  always #10 clk_in = ~clk_in;
  scsa_sense_model scsa_sense_model_inst (.clk_in(clk_in), .fp_out(fp),
    .fs_out(fs), .ap_out(ap), .sa_out(sa), .vp_out(vp), .vs_out(vs),
    .vf_out(vf));
  scsa_core scsa_core_inst (.clk_in(clk_in), .rst_in(rst_in),
    .clk_en_in(en), .avs_address_in(av_addr), .avs_read_in(av_rd),
    .avs_write_in(av_wr), .avs_writedata_in(av_wdata),
    .avs_byteenable_in(4'hf), .avs_readdata_out(av_rdata),
    .avs_waitrequest_out(av_wait), .freq_primary_in(fp),
    .freq_sync_in(fs), .angle_primary_in(ap), .angle_sync_in(sa),
    .volt_primary_in(vp), .volt_sync_in(vs), .volt_freq_ref_in(vf),
    .sync_block_condition_in(blk), .primary_voltage_healthy_out(hp),
    .sync_voltage_healthy_out(hs), .freq_ref_voltage_healthy_out(hf),
    .slip_ok_out(slip_ok), .sync_ok_first_out(ok1),
    .sync_ok_second_out(ok2), .irq_out(irq));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // one access, held until waitrequest is sampled low
  task bus(input w, input [5:0] a, input [31:0] d);
    integer n;
    begin
      {av_addr, av_wdata, av_wr, av_rd} <= {a, d, w, !w};
      n = 0;
      @(posedge clk_in);
      while (av_wait !== 1'b0 && n < 40) begin
        n = n + 1;
        @(posedge clk_in);
      end
      if (n >= 40) n_errors = n_errors + 1;
      rdata = av_rdata;
      {av_wr, av_rd} <= 2'b00;
      @(posedge clk_in);
    end
  endtask
  task rc(input [5:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(rdata, e);
    end
  endtask
  task pause;
    repeat (4) @(posedge clk_in);
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    n_errors = n_errors + 1;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rc(6'h00, 32'h32);
    rc(6'h04, 32'h96);
    rc(6'h08, 32'hfa);
    rc(6'h0c, 32'h0);
    rc(6'h10, 32'h0);
    rc(6'h14, 32'h190);
    rc(6'h18, 32'h578);
    rc(6'h2c, 32'h0);
    rc(6'h30, 32'h0);
    $display("test reset values done");
    // -0.100 Hz slip against limits at and just over its magnitude
    scsa_sense_model_inst.set_f(16'hea2e, 16'hea92, 12'h258, 12'h0);
    pause;
    rc(6'h20, 32'hffffff9c);
    chk(slip_ok, 1'b0);
    chk(ok1, 1'b0);
    bus(1'b1, 6'h00, 32'h64);
    pause;
    chk(slip_ok, 1'b0);
    bus(1'b1, 6'h00, 32'h65);
    pause;
    chk(slip_ok, 1'b1);
    rc(6'h24, 32'h258);
    bus(1'b1, 6'h10, 32'h3e8);
    pause;
    rc(6'h24, 32'h21c);
    scsa_sense_model_inst.set_f(16'hea2e, 16'hea92, 12'h3c, 12'h0);
    pause;
    chk(ok1, 1'b1);
    // short of zero and closing: held off; past zero and opening: granted
    scsa_sense_model_inst.set_f(16'hea2e, 16'hea92, 12'h50, 12'h0);
    pause;
    chk({ok1, ok2}, 2'b00);
    scsa_sense_model_inst.set_f(16'hea2e, 16'hea92, 12'h28, 12'h0);
    pause;
    chk({ok1, ok2}, 2'b11);
    $display("test slipping done");
    scsa_sense_model_inst.set_f(16'hea65, 16'hea60, 12'h258, 12'h0);
    pause;
    rc(6'h24, 32'h258);
    scsa_sense_model_inst.set_f(16'hea66, 16'hea60, 12'h258, 12'h0);
    pause;
    rc(6'h20, 32'h6);
    rc(6'h24, 32'h25b);
    $display("test static edge done");
    for (k = 0; k < 12; k = k + 1) begin
      bus(1'b1, 6'h0c, k);
      scsa_sense_model_inst.set_f(16'hea60, 16'hea60,
        (100 + 300 * k) % 3600, 12'h0);
      pause;
      rc(6'h24, 32'h64);
      chk(ok1, 1'b1);
    end
    bus(1'b1, 6'h0c, 32'h0);
    scsa_sense_model_inst.set_f(16'hea60, 16'hea60, 12'h96, 12'h0);
    pause;
    chk({ok1, ok2}, 2'b01);
    scsa_sense_model_inst.set_f(16'hea60, 16'hea60, 12'h64, 12'hdac);
    pause;
    rc(6'h24, 32'hc8);
    $display("test angle done");
    blk <= 1'b1;
    pause;
    chk({slip_ok, ok2}, 2'b00);
    blk <= 1'b0;
    scsa_sense_model_inst.set_v(12'h579, 12'h578, 12'h190);
    pause;
    chk({hp, hs, hf, slip_ok}, 4'b0110);
    // full scale on the primary, one step under the low limit on sync
    scsa_sense_model_inst.set_v(12'hfff, 12'h18f, 12'h4b0);
    pause;
    chk({hp, hs}, 2'b00);
    scsa_sense_model_inst.set_v(12'h4b0, 12'h4b0, 12'h4b0);
    scsa_sense_model_inst.set_f(16'hea60, 16'hea60, 12'h0, 12'h0);
    $display("test healthy done");
    // with the enable low a block must not reach the outputs
    pause;
    en <= 1'b0;
    blk <= 1'b1;
    pause;
    chk({slip_ok, ok1, ok2}, 3'b111);
    en <= 1'b1;
    $display("test clock enable done");
    // events while masked stay sticky but keep the line low
    blk <= 1'b1;
    pause;
    bus(1'b0, 6'h28, 32'h0);
    blk <= 1'b0;
    pause;
    chk(irq, 1'b0);
    bus(1'b1, 6'h2c, 32'h1);
    pause;
    chk(irq, 1'b1);
    rc(6'h28, 32'h7);
    pause;
    chk(irq, 1'b0);
    rc(6'h28, 32'h0);
    rc(6'h1c, 32'h3f);
    $display("test interrupt done");
    print_verdict;
  end
endmodule // scsa_core_tb_top
`default_nettype wire
